// ===== design/dlab_pkg.sv
package dlab_pkg;

    // ------------------------------------------------------------
    // Clock and link rates
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned NUM_RATES = 4;
    localparam logic [1:0] RATE_FIRST = 2'h0;
    localparam logic [1:0] RATE_LAST = 2'h3;
    localparam int unsigned BAUD_38400 = 38400;
    localparam int unsigned BAUD_19200 = 19200;
    localparam int unsigned BAUD_9600 = 9600;
    localparam int unsigned BAUD_4800 = 4800;

    // ------------------------------------------------------------
    // Drive addresses
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_FIRST = 4'h1;
    localparam logic [3:0] ADDR_LAST = 4'hf;

    // ------------------------------------------------------------
    // Timeout extension
    // ------------------------------------------------------------
    localparam int unsigned EXTRA_STEP_MS = 14;
    localparam int unsigned EXTRA_STEP_CYC = EXTRA_STEP_MS * (CLK_HZ / 1000);

    typedef enum logic [2:0] {
        DLAB_IDLE = 3'b000,
        DLAB_POLL = 3'b001,
        DLAB_WAIT = 3'b010,
        DLAB_NEXT = 3'b011,
        DLAB_LOCK = 3'b100
    } dlab_state_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [1:0] rate;
    } dlab_poll_t;

    // Bit period in clock cycles for a rate index, fastest first.
    function automatic logic [15:0] dlab_bit_cycles(input logic [1:0] rate);
        case (rate)
            2'h0: dlab_bit_cycles = 16'(CLK_HZ / BAUD_38400);
            2'h1: dlab_bit_cycles = 16'(CLK_HZ / BAUD_19200);
            2'h2: dlab_bit_cycles = 16'(CLK_HZ / BAUD_9600);
            default: dlab_bit_cycles = 16'(CLK_HZ / BAUD_4800);
        endcase
    endfunction

endpackage

// ===== design/dlab_search.sv
// What this block does
// - While searching, each rate is tried in turn with drive addresses polled from 1 up to 15.
// - The first good answer locks the rate then in use until reset.
// - A full pass with no answer starts the pass again until a rate locks.
// - Only 38400, 19200, 9600 and 4800 bit/s are supported and searched.
// - The locked rate is that of the first drive found and serves every drive afterwards.
// - Drives at another rate are never marked present in the connected-drive status.
// - The answer timeout grows by 0, 14, 28 or 42 ms for a two-bit setting of 0 to 3.
`timescale 1ns/10ps
`default_nettype none

module dlab_search
    import dlab_pkg::*;
#(
    parameter int unsigned BASE_TIMEOUT_CYC = 400_000,
    parameter int unsigned EXTRA_STEP = EXTRA_STEP_CYC
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic clk_en,
    // Configuration pins
    input wire logic [1:0] delay_sel,
    // Poll engine
    output logic poll_start,
    output dlab_pkg::dlab_poll_t poll_req,
    output logic [15:0] bit_cycles,
    input wire logic poll_done,
    input wire logic answer_ok,
    // Status
    output logic locked,
    output logic [1:0] locked_rate,
    output logic [15:1] drive_present
);
    import dlab_pkg::*;

    // Timer arithmetic is 32 bits wide; the largest limit must leave room to count past it.
    if (BASE_TIMEOUT_CYC < 1 ||
        64'(BASE_TIMEOUT_CYC) + 64'h3 * 64'(EXTRA_STEP) > 64'hffff_fff0) begin : g_bad_timeout
        $error("dlab_search: timeout parameters out of range");
    end

    // Next drive in polling order; the walk wraps from the last drive back to the first.
    function automatic logic [3:0] dlab_next_addr(input logic [3:0] addr);
        dlab_next_addr = (addr == ADDR_LAST) ? ADDR_FIRST : addr + 4'h1;
    endfunction

    // ------------------------------------------------------------
    // Delay setting filter
    // ------------------------------------------------------------
    // The setting comes from switches outside the clock domain. A change only counts
    // once the last two stages agree, so a value seen for only one sample never reaches the timer.
    logic [1:0] sel_s1_q, sel_s1_d;
    logic [1:0] sel_s2_q, sel_s2_d;
    logic [1:0] sel_s3_q, sel_s3_d;
    logic [1:0] delay_q, delay_d;

    always_comb begin
        sel_s1_d = delay_sel;
        sel_s2_d = sel_s1_q;
        sel_s3_d = sel_s2_q;
        delay_d = (sel_s2_q == sel_s3_q) ? sel_s2_q : delay_q;
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sel_s1_q <= '0;
            sel_s2_q <= '0;
            sel_s3_q <= '0;
            delay_q <= '0;
        end else if (clk_en) begin
            sel_s1_q <= sel_s1_d;
            sel_s2_q <= sel_s2_d;
            sel_s3_q <= sel_s3_d;
            delay_q <= delay_d;
        end
    end

    // ------------------------------------------------------------
    // Search state
    // ------------------------------------------------------------
    dlab_state_t state_q, state_d;
    logic [3:0] addr_q, addr_d;
    logic [1:0] rate_q, rate_d;
    logic [31:0] timer_q, timer_d;
    logic [15:1] present_q, present_d;
    logic start_q, start_d;
    logic locked_q, locked_d;
    logic [15:0] bits_q, bits_d;
    logic [31:0] limit;

    // The extra delay helps slow drives; it costs search time on every silent address.
    assign limit = BASE_TIMEOUT_CYC + 32'(delay_q) * EXTRA_STEP;

    always_comb begin
        state_d = state_q;
        addr_d = addr_q;
        rate_d = rate_q;
        timer_d = timer_q;
        present_d = present_q;
        start_d = 1'b0;
        case (state_q)
            DLAB_IDLE: begin
                state_d = DLAB_POLL;
            end
            DLAB_POLL: begin
                start_d = 1'b1;
                timer_d = '0;
                state_d = DLAB_WAIT;
            end
            DLAB_WAIT: begin
                timer_d = timer_q + 32'h1;
                if (poll_done && answer_ok) begin
                    // The lock loop starts its own poll at once, on the next drive.
                    present_d[addr_q] = 1'b1;
                    addr_d = dlab_next_addr(addr_q);
                    timer_d = '0;
                    state_d = DLAB_LOCK;
                end else if (poll_done || timer_q >= limit) begin
                    state_d = DLAB_NEXT;
                end
            end
            DLAB_NEXT: begin
                if (addr_q == ADDR_LAST) begin
                    addr_d = ADDR_FIRST;
                    rate_d = (rate_q == RATE_LAST) ? RATE_FIRST : rate_q + 2'h1;
                end else begin
                    addr_d = addr_q + 4'h1;
                end
                state_d = DLAB_POLL;
            end
            DLAB_LOCK: begin
                // Locked: keep cycling addresses at the held rate to serve every drive.
                if (start_q == 1'b0 && timer_q == '0) begin
                    start_d = 1'b1;
                end
                timer_d = timer_q + 32'h1;
                if (poll_done || timer_q >= limit) begin
                    if (poll_done) begin
                        present_d[addr_q] = answer_ok;
                    end
                    addr_d = dlab_next_addr(addr_q);
                    timer_d = '0;
                end
            end
            default: begin
                state_d = DLAB_IDLE;
            end
        endcase
        // Status is taken from the next state, so the registered copies lag nothing.
        locked_d = (state_d == DLAB_LOCK);
        bits_d = dlab_bit_cycles(rate_d);
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= DLAB_IDLE;
            addr_q <= ADDR_FIRST;
            rate_q <= RATE_FIRST;
            timer_q <= '0;
            present_q <= '0;
            start_q <= 1'b0;
            locked_q <= 1'b0;
            bits_q <= 16'(CLK_HZ / BAUD_38400);
        end else if (clk_en) begin
            state_q <= state_d;
            addr_q <= addr_d;
            rate_q <= rate_d;
            timer_q <= timer_d;
            present_q <= present_d;
            start_q <= start_d;
            locked_q <= locked_d;
            bits_q <= bits_d;
        end
    end

    assign poll_start = start_q;
    assign poll_req = '{addr: addr_q, rate: rate_q};
    assign bit_cycles = bits_q;
    assign locked = locked_q;
    assign locked_rate = rate_q;
    assign drive_present = present_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_rate_held: assert property (@(posedge core_clk) disable iff (!resetn)
        locked |=> locked && $stable(rate_q)) else $error("rate changed after lock");
    a_rate_step: assert property (@(posedge core_clk) disable iff (!resetn)
        (clk_en && state_q == DLAB_NEXT && addr_q != ADDR_LAST) |=> addr_q == $past(addr_q) + 4'h1 && $stable(rate_q))
        else $error("address did not step");
    a_pass_wrap: assert property (@(posedge core_clk) disable iff (!resetn)
        (clk_en && state_q == DLAB_NEXT && addr_q == ADDR_LAST) |=> addr_q == ADDR_FIRST && state_q == DLAB_POLL)
        else $error("pass did not restart");
    a_lock_first: assert property (@(posedge core_clk) disable iff (!resetn)
        (clk_en && state_q == DLAB_WAIT && poll_done && answer_ok) |=> locked && rate_q == $past(rate_q))
        else $error("lock missed first answer");
    a_no_ghost: assert property (@(posedge core_clk) disable iff (!resetn)
        !locked |-> drive_present == '0) else $error("drive present without lock");
    a_time_out: assert property (@(posedge core_clk) disable iff (!resetn)
        (clk_en && state_q == DLAB_WAIT && !poll_done && timer_q >= limit) |=> state_q == DLAB_NEXT)
        else $error("timeout not honoured");
    a_poll_pulse: assert property (@(posedge core_clk) disable iff (!resetn)
        (clk_en && state_q == DLAB_POLL) |=> poll_start && state_q == DLAB_WAIT) else $error("poll not issued");
    a_rate_range: assert property (@(posedge core_clk) disable iff (!resetn)
        bit_cycles >= 16'(CLK_HZ / BAUD_38400)) else $error("rate outside supported set");
    a_bits_match: assert property (@(posedge core_clk) disable iff (!resetn)
        bit_cycles == 16'(CLK_HZ / (BAUD_38400 >> locked_rate))) else $error("bit period does not match rate");
    a_loop_step: assert property (@(posedge core_clk) disable iff (!resetn)
        (clk_en && locked && poll_done) |=> addr_q == dlab_next_addr($past(addr_q)))
        else $error("lock loop did not move on");
    a_sel_filter: assert property (@(posedge core_clk) disable iff (!resetn)
        (clk_en && sel_s2_q != sel_s3_q) |=> $stable(delay_q)) else $error("unsettled delay setting used");

    c_lock: cover property (@(posedge core_clk) disable iff (!resetn) $rose(locked));
    c_rate_wrap: cover property (@(posedge core_clk) disable iff (!resetn)
        state_q == DLAB_NEXT && rate_q == RATE_LAST && addr_q == ADDR_LAST);
    c_timeout: cover property (@(posedge core_clk) disable iff (!resetn)
        state_q == DLAB_WAIT && timer_q >= limit);
    c_lock_loop: cover property (@(posedge core_clk) disable iff (!resetn)
        locked && poll_done && answer_ok);

endmodule // dlab_search

`default_nettype wire

// ===== bench/dlab_drive_model.sv
`timescale 1ns/10ps
`default_nettype none
module dlab_drive_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Fitted drives, their rates and reply delay
    input wire logic [15:1] fit_a,
    input wire logic [1:0] rate_a,
    input wire logic [15:1] fit_b,
    input wire logic [1:0] rate_b,
    input wire logic [7:0] reply_dly,
    // Poll link
    input wire logic poll_start,
    input wire dlab_pkg::dlab_poll_t poll_req,
    output logic poll_done,
    output logic answer_ok
);
    import dlab_pkg::*;
    logic [7:0] wait_q;
    logic hit_q, busy_q, noise_q;
    // A drive set to any other rate stays silent, so the poll times out.
    always @(negedge core_clk or negedge resetn) begin
        if (!resetn) begin
            {busy_q, hit_q, noise_q, poll_done, wait_q} <= '0;
        end else begin
            poll_done <= 1'b0;
            noise_q <= ~noise_q;
            if (poll_start && !busy_q) begin
                busy_q <= 1'b1;
                wait_q <= reply_dly;
                hit_q <= (fit_a[poll_req.addr] && poll_req.rate == rate_a) ||
                         (fit_b[poll_req.addr] && poll_req.rate == rate_b);
            end else if (busy_q && wait_q == 8'h00) begin
                busy_q <= 1'b0;
                poll_done <= hit_q;
            end else if (busy_q) begin
                wait_q <= wait_q - 8'h01;
            end
        end
    end
    // Between replies the answer line carries noise that toggles every cycle.
    assign answer_ok = poll_done ? 1'b1 : noise_q;
endmodule // dlab_drive_model
`default_nettype wire

// ===== bench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import dlab_pkg::*;
    localparam int STEP = 20;
    localparam int MAX_CYCLES = 20000;
    logic core_clk, resetn, clk_en, poll_start, poll_done, answer_ok, locked;
    logic [1:0] delay_sel, locked_rate, rate_a, rate_b;
    logic [15:1] drive_present, fit_a, fit_b;
    logic [15:0] bit_cycles;
    logic [7:0] reply_dly;
    dlab_poll_t poll_req, exp_q;
    int bad_count = 0, cmp_count = 0, cycles = 0, last_t = 0, gap = 0, poll_n = 0;

    dlab_search #(.BASE_TIMEOUT_CYC(50), .EXTRA_STEP(STEP)) dlab_search_inst (.core_clk(core_clk),
        .resetn(resetn), .clk_en(clk_en), .delay_sel(delay_sel), .poll_start(poll_start),
        .poll_req(poll_req), .bit_cycles(bit_cycles), .poll_done(poll_done), .answer_ok(answer_ok),
        .locked(locked), .locked_rate(locked_rate), .drive_present(drive_present));
    dlab_drive_model dlab_drive_model_inst (.core_clk(core_clk), .resetn(resetn), .fit_a(fit_a),
        .rate_a(rate_a), .fit_b(fit_b), .rate_b(rate_b), .reply_dly(reply_dly),
        .poll_start(poll_start), .poll_req(poll_req), .poll_done(poll_done), .answer_ok(answer_ok));

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
        cmp_count++;
        if (seen !== want) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, want, seen);
        end
    endtask

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Every poll is judged here, half a cycle after the edge that launched it.
    always @(negedge core_clk) begin
        cycles++;
        if (cycles > MAX_CYCLES) begin
            bad_count++;
            end_of_test();
        end else if (resetn && poll_start) begin
            poll_n++;
            gap = cycles - last_t;
            last_t = cycles;
            check("bit period", bit_cycles, CLK_HZ / (BAUD_38400 >> poll_req.rate));
            if (!locked) begin
                check("poll order", poll_req, exp_q);
                exp_q.rate = exp_q.addr == ADDR_LAST ? exp_q.rate + 2'h1 : exp_q.rate;
                exp_q.addr = exp_q.addr == ADDR_LAST ? ADDR_FIRST : exp_q.addr + 4'h1;
            end else begin
                check("locked poll rate", poll_req.rate, locked_rate);
            end
        end
    end

    task automatic do_reset(input logic [1:0] sel);
        @(negedge core_clk);
        resetn = 1'b0;
        delay_sel = sel;
        fit_a = '0;
        fit_b = '0;
        repeat (6) @(negedge core_clk);
        exp_q = '{addr: ADDR_FIRST, rate: RATE_FIRST};
        poll_n = 0;
        check("locked in reset", locked, 0);
        check("present in reset", drive_present, 0);
        check("start in reset", {poll_start, poll_req}, {1'b0, ADDR_FIRST, RATE_FIRST});
        resetn = 1'b1;
    endtask

    task automatic wait_polls(input int n);
        while (poll_n < n) @(posedge core_clk);
        @(negedge core_clk);
    endtask

    // Lock on drive 7 at the third rate; drive 3 at another rate stays unseen.
    task automatic search_lock();
        fit_a = 15'h0040;
        rate_a = 2'h2;
        fit_b = 15'h0004;
        rate_b = 2'h3;
        wait_polls(80);
        check("locked rate", {locked, locked_rate}, 3'h6);
        check("present map", drive_present, 15'h0040);
    endtask

    // Clock enable low freezes the lock loop; nothing moves until it returns.
    task automatic freeze_hold();
        dlab_poll_t held;
        logic [15:1] map;
        held = poll_req;
        map = drive_present;
        clk_en = 1'b0;
        repeat (120) @(negedge core_clk);
        check("frozen poll", poll_req, held);
        check("frozen map", drive_present, map);
        check("frozen lock", {locked, locked_rate}, 3'h6);
        clk_en = 1'b1;
    endtask

    // A full silent pass wraps, then a slow drive found on the second pass locks.
    task automatic repeat_pass();
        reply_dly = 8'd20;
        wait_polls(61);
        check("no lock yet", locked, 0);
        fit_a = 15'h0002;
        rate_a = 2'h0;
        wait_polls(64);
        check("second pass lock", {locked, locked_rate}, 3'h4);
    endtask

    task automatic delay_steps();
        int g0;
        for (int s = 0; s < 4; s++) begin
            do_reset(2'(s));
            wait_polls(2);
            if (s == 0) g0 = gap;
            check("timeout step", gap - g0, s * STEP);
        end
    endtask

    initial begin
        {resetn, clk_en, delay_sel, fit_a, fit_b, rate_a, rate_b} = '0;
        clk_en = 1'b1;
        reply_dly = 8'd5;
        do_reset(2'h0);
        search_lock();
        freeze_hold();
        do_reset(2'h0);
        repeat_pass();
        delay_steps();
        end_of_test();
    end
endmodule // testbench
`default_nettype wire
